// ===== acf_pkg.sv
package acf_pkg;

  localparam int ACF_WIDTH = 8;

  // Flag positions inside the condition flags register (arbitrary layout)
  localparam int ACF_FLAG_N = 3;
  localparam int ACF_FLAG_C = 2;
  localparam int ACF_FLAG_V = 1;
  localparam int ACF_FLAG_Z = 0;
  localparam logic [3:0] ACF_FLAGS_RESET = 4'h0;

  // T-state counts
  localparam logic [1:0] ACF_TSTATES_REG = 2'h2;
  localparam logic [1:0] ACF_TSTATES_MEM = 2'h3;

  typedef enum logic [3:0] {
    ACF_OP_ADD,
    ACF_OP_ADC,
    ACF_OP_SUB,
    ACF_OP_SBC,
    ACF_OP_CMP,
    ACF_OP_CPL,
    ACF_OP_AND,
    ACF_OP_OR,
    ACF_OP_XOR,
    ACF_OP_BIT,
    ACF_OP_SHL,
    ACF_OP_SHR,
    ACF_OP_ROR,
    ACF_OP_NOP
  } acf_op_e;

  typedef struct packed {
    logic n;
    logic c;
    logic v;
    logic z;
  } acf_flags_s;

  typedef struct packed {
    logic [7:0] res;
    acf_flags_s flg;
    logic       wrRes;
    logic [3:0] mask;
  } acf_result_s;

endpackage : acf_pkg

// ===== acf_shifter.sv
`timescale 1ns/1ps
module acf_shifter
  import acf_pkg::*;
(
  // Operand and control
  input  wire logic [7:0] opA,
  input  wire logic [2:0] amt,
  input  wire logic       left,
  input  wire logic       rot,
  // Result
  output logic      [7:0] res,
  output logic            cOut
);

  logic [15:0] wideL;
  logic [15:0] wideR;

  always_comb begin
    wideL = {8'h00, opA} << amt;
    wideR = {opA, 8'h00} >> amt;
    cOut  = 1'b0;
    if (rot) begin
      res = wideR[15:8] | wideR[7:0];
      // Last bit rotated lands in the MSB of the result
      cOut = (amt != 3'h0) ? res[7] : 1'b0;
    end else if (left) begin
      res  = wideL[7:0];
      cOut = (amt != 3'h0) ? wideL[8] : 1'b0;
    end else begin
      res  = wideR[15:8];
      cOut = (amt != 3'h0) ? wideR[7] : 1'b0;
    end
  end

endmodule : acf_shifter

// ===== acf_adder.sv
`timescale 1ns/1ps
module acf_adder
  import acf_pkg::*;
#(
  parameter int W = 8
)
(
  // Operands
  input  wire logic [W-1:0] a,
  input  wire logic [W-1:0] b,
  input  wire logic         cin,
  // Sum
  output logic      [W-1:0] sum,
  output logic              cout
);

  logic [W-1:0] gen;
  logic [W-1:0] prp;
  logic [W:0]   cry;

  assign gen = a & b;
  assign prp = a ^ b;

  // Carry of each bit from generate/propagate terms, no ripple chain
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_cla
      logic [gi:0] term;
      always_comb begin
        for (int k = 0; k <= gi; k++) begin
          term[k] = gen[k];
          for (int j = k + 1; j <= gi; j++) begin
            term[k] = term[k] & prp[j];
          end
        end
      end
      assign cry[gi+1] = (|term) | (cin & (&prp[gi:0]));
    end
  endgenerate

  assign cry[0] = cin;
  assign sum    = prp ^ cry[W-1:0];
  assign cout   = cry[W];

endmodule : acf_adder

// ===== acf_alu.sv
`timescale 1ns/1ps
// Contract
// - 8-bit operands, carry look-ahead, any register as source or destination
// - Register destination completes in two T-states
// - Memory destination via indirect addressing completes in three T-states
// - Add with/without carry, subtract with/without borrow held in carry
// - Subtract adds two's complement of subtrahend; result in two's complement
// - Logic ops: complement, AND, OR, XOR, compare, bit test
// - Shift left/right 0..7 bits and rotate right 0..7 bits
// - Shifts and rotates only on a register, never to memory
// - Negative flag equals result MSB when affected
// - Carry set on add carry out or subtract/compare borrow
// - Carry takes last shifted or rotated bit; otherwise cleared
// - Overflow set when signed arithmetic or compare result not representable
// - Zero flag set only for all-zero result
// - Unaffected flags keep their previous value
// - All four flags readable and writable as condition flags register
// - Flags pushed on call/interrupt, restored only on return with restore
// - Flags computed in parallel with result, no extra cycles
// - Unsigned relations decoded from carry and zero after x minus y
// - Signed relations decoded from negative XOR overflow and zero
module acf_alu
  import acf_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  // Operation request, one T-state per clock
  input  wire logic       start,
  input  wire acf_op_e    op,
  input  wire logic [7:0] srcA,
  input  wire logic [7:0] srcB,
  input  wire logic [2:0] shAmt,
  input  wire logic       memDest,
  // Condition flags register access
  input  wire logic       flagsWe,
  input  wire logic [3:0] flagsWData,
  output logic      [3:0] condition_flags_register,
  // Stack save and restore
  input  wire logic       pushFlags,
  output logic      [3:0] flagsPushData,
  input  wire logic       retRestore,
  input  wire logic [3:0] flagsPopData,
  // Result delivery
  output logic            busy,
  output logic            regWe,
  output logic            memWe,
  output logic      [7:0] result,
  output logic            reject,
  // Comparison decode
  output logic      [4:0] unsRel,
  output logic      [4:0] sgnRel
);

  typedef enum logic [1:0] {ST_IDLE, ST_T1, ST_TX, ST_T2} acf_state_e;

  acf_state_e  state_r;
  acf_state_e  state_nxt;
  acf_result_s calc;
  acf_result_s hold_r;
  acf_flags_s  flags_r;
  logic        isShift;
  logic        isArith;
  logic        isSub;
  logic [7:0]  addB;
  logic        addCin;
  logic [7:0]  sum;
  logic        cout;
  logic [7:0]  shRes;
  logic        shC;
  logic        mem_r;
  logic [1:0]  tCnt_r;
  logic [7:0]  cmpA_r;
  logic [7:0]  cmpB_r;
  logic        cmpSub_r;

  function automatic logic is_shift_op(input acf_op_e o);
    return (o == ACF_OP_SHL) || (o == ACF_OP_SHR) || (o == ACF_OP_ROR);
  endfunction : is_shift_op

  assign isShift = is_shift_op(op);
  assign isSub   = (op == ACF_OP_SUB) || (op == ACF_OP_SBC) ||
                   (op == ACF_OP_CMP);
  assign isArith = isSub || (op == ACF_OP_ADD) || (op == ACF_OP_ADC);

  // Subtrahend inverted plus one; borrow in removes the one
  assign addB = isSub ? ~srcB : srcB;
  always_comb begin
    case (op)
      ACF_OP_ADC: addCin = flags_r.c;
      ACF_OP_SBC: addCin = ~flags_r.c;
      ACF_OP_SUB: addCin = 1'b1;
      ACF_OP_CMP: addCin = 1'b1;
      default:    addCin = 1'b0;
    endcase
  end

  acf_adder #(.W(ACF_WIDTH)) u_add (
    .a   (srcA),
    .b   (addB),
    .cin (addCin),
    .sum (sum),
    .cout(cout)
  );

  acf_shifter u_sh (
    .opA (srcA),
    .amt (shAmt),
    .left(op == ACF_OP_SHL),
    .rot (op == ACF_OP_ROR),
    .res (shRes),
    .cOut(shC)
  );

  // Result and flags in the same combinational pass
  always_comb begin
    calc       = '0;
    calc.wrRes = 1'b1;
    calc.mask  = 4'hF;
    case (op)
      ACF_OP_ADD, ACF_OP_ADC, ACF_OP_SUB, ACF_OP_SBC, ACF_OP_CMP: begin
        calc.res   = sum;
        calc.flg.c = isSub ? ~cout : cout;
        calc.flg.v = (srcA[7] == addB[7]) && (sum[7] != srcA[7]);
        calc.wrRes = (op != ACF_OP_CMP);
      end
      ACF_OP_CPL: calc.res = ~srcA;
      ACF_OP_AND: calc.res = srcA & srcB;
      ACF_OP_OR:  calc.res = srcA | srcB;
      ACF_OP_XOR: calc.res = srcA ^ srcB;
      ACF_OP_BIT: begin
        calc.res   = srcA & srcB;
        calc.wrRes = 1'b0;
      end
      ACF_OP_SHL, ACF_OP_SHR, ACF_OP_ROR: begin
        calc.res   = shRes;
        calc.flg.c = shC;
      end
      default: begin
        calc.res   = srcA;
        calc.wrRes = 1'b0;
        calc.mask  = 4'h0;
      end
    endcase
    calc.flg.n = calc.res[7];
    calc.flg.z = (calc.res == 8'h00);
    // Logic ops leave overflow alone, carry cleared
    if (!isArith && !isShift && op != ACF_OP_NOP) begin
      calc.mask = 4'hD;
    end
  end

  // Shift or rotate to memory is refused outright
  assign reject = start && (state_r == ST_IDLE) && memDest && isShift;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (start && !reject) state_nxt = ST_T1;
      ST_T1:   state_nxt = mem_r ? ST_TX : ST_T2;
      ST_TX:   state_nxt = ST_T2;
      ST_T2:   state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hold_r   <= '0;
      mem_r    <= 1'b0;
      cmpA_r   <= 8'h00;
      cmpB_r   <= 8'h00;
      cmpSub_r <= 1'b0;
    end else if (state_r == ST_IDLE && start && !reject) begin
      hold_r   <= calc;
      mem_r    <= memDest;
      cmpA_r   <= srcA;
      cmpB_r   <= srcB;
      cmpSub_r <= (op == ACF_OP_SUB) || (op == ACF_OP_CMP);
    end
  end

  // Counts T-states of the operation in flight, only for the length check
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tCnt_r <= 2'h0;
    end else if (state_nxt == ST_IDLE) begin
      tCnt_r <= 2'h0;
    end else begin
      tCnt_r <= tCnt_r + 2'h1;
    end
  end

  // Flags: restore beats direct write beats instruction update
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      flags_r <= ACF_FLAGS_RESET;
    end else if (retRestore) begin
      flags_r <= flagsPopData;
    end else if (flagsWe) begin
      flags_r <= flagsWData;
    end else if (state_r == ST_T1) begin
      if (hold_r.mask[ACF_FLAG_N]) flags_r.n <= hold_r.flg.n;
      if (hold_r.mask[ACF_FLAG_C]) flags_r.c <= hold_r.flg.c;
      if (hold_r.mask[ACF_FLAG_V]) flags_r.v <= hold_r.flg.v;
      if (hold_r.mask[ACF_FLAG_Z]) flags_r.z <= hold_r.flg.z;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      result <= 8'h00;
    end else if (state_r == ST_T1) begin
      result <= hold_r.res;
    end
  end

  assign condition_flags_register = flags_r;
  assign flagsPushData = flags_r;
  assign busy  = (state_r != ST_IDLE);
  assign regWe = (state_r == ST_T2) && !mem_r && hold_r.wrRes;
  assign memWe = (state_r == ST_T2) && mem_r && hold_r.wrRes;

  // Relations valid after a subtract or compare of x minus y
  assign unsRel[0] = flags_r.c;
  assign unsRel[1] = flags_r.c | flags_r.z;
  assign unsRel[2] = flags_r.z;
  assign unsRel[3] = ~flags_r.c;
  assign unsRel[4] = ~flags_r.c & ~flags_r.z;
  assign sgnRel[0] = flags_r.n ^ flags_r.v;
  assign sgnRel[1] = flags_r.z | (flags_r.n ^ flags_r.v);
  assign sgnRel[2] = flags_r.z;
  assign sgnRel[3] = ~(flags_r.n ^ flags_r.v);
  assign sgnRel[4] = ~(flags_r.n ^ flags_r.v) & ~flags_r.z;

  sequence s_reg_walk;
    (state_r == ST_T1) ##1 (state_r == ST_T2) ##1 !busy;
  endsequence

  sequence s_mem_walk;
    busy [*3] ##1 !busy;
  endsequence

  property p_reg_two;
    @(posedge clk_sys) disable iff (!rstn)
      (state_r == ST_IDLE && start && !reject && !memDest)
        |=> s_reg_walk;
  endproperty
  a_reg_two: assert property (p_reg_two) else $error("reg op length");

  property p_mem_three;
    @(posedge clk_sys) disable iff (!rstn)
      (state_r == ST_IDLE && start && !reject && memDest)
        |=> s_mem_walk;
  endproperty
  a_mem_three: assert property (p_mem_three) else $error("mem op length");

  property p_no_mem_shift;
    @(posedge clk_sys) disable iff (!rstn)
      (state_r == ST_IDLE && start && memDest && isShift) |=> !busy;
  endproperty
  a_no_mem_shift: assert property (p_no_mem_shift)
    else $error("shift to memory accepted");

  property p_zero_flag;
    @(posedge clk_sys) disable iff (!rstn)
      (state_r == ST_T1 && hold_r.mask[ACF_FLAG_Z] && !flagsWe && !retRestore)
        |=> flags_r.z == (result == 8'h00);
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag");

  property p_neg_flag;
    @(posedge clk_sys) disable iff (!rstn)
      (state_r == ST_T1 && hold_r.mask[ACF_FLAG_N] && !flagsWe && !retRestore)
        |=> flags_r.n == result[7];
  endproperty
  a_neg_flag: assert property (p_neg_flag) else $error("negative flag");

  property p_keep;
    @(posedge clk_sys) disable iff (!rstn)
      (state_r != ST_T1 && !flagsWe && !retRestore) |=> $stable(flags_r);
  endproperty
  a_keep: assert property (p_keep) else $error("flags changed");

  property p_restore;
    @(posedge clk_sys) disable iff (!rstn)
      retRestore |=> condition_flags_register == $past(flagsPopData);
  endproperty
  a_restore: assert property (p_restore) else $error("restore");

  property p_write;
    @(posedge clk_sys) disable iff (!rstn)
      (flagsWe && !retRestore) |=> flags_r == $past(flagsWData);
  endproperty
  a_write: assert property (p_write) else $error("flags write");

  property p_uns_eq;
    @(posedge clk_sys) disable iff (!rstn)
      unsRel[2] == sgnRel[2] && (unsRel[0] != unsRel[3]);
  endproperty
  a_uns_eq: assert property (p_uns_eq) else $error("relations");

  property p_t_count;
    @(posedge clk_sys) disable iff (!rstn)
      (state_r == ST_T2)
        |-> tCnt_r == (mem_r ? ACF_TSTATES_MEM : ACF_TSTATES_REG);
  endproperty
  a_t_count: assert property (p_t_count)
    else $error("T-state count");

  property p_uns_rel;
    @(posedge clk_sys) disable iff (!rstn)
      (state_r == ST_T1 && cmpSub_r && !flagsWe && !retRestore)
        |=> unsRel == {cmpA_r > cmpB_r, cmpA_r >= cmpB_r, cmpA_r == cmpB_r,
                       cmpA_r <= cmpB_r, cmpA_r < cmpB_r};
  endproperty
  a_uns_rel: assert property (p_uns_rel)
    else $error("unsigned relation");

  property p_sgn_rel;
    @(posedge clk_sys) disable iff (!rstn)
      (state_r == ST_T1 && cmpSub_r && !flagsWe && !retRestore)
        |=> sgnRel == {$signed(cmpA_r) > $signed(cmpB_r),
                       $signed(cmpA_r) >= $signed(cmpB_r),
                       cmpA_r == cmpB_r,
                       $signed(cmpA_r) <= $signed(cmpB_r),
                       $signed(cmpA_r) < $signed(cmpB_r)};
  endproperty
  a_sgn_rel: assert property (p_sgn_rel)
    else $error("signed relation");

  property p_logic_carry;
    @(posedge clk_sys) disable iff (!rstn)
      (state_r == ST_T1 && hold_r.mask == 4'hD && !flagsWe && !retRestore)
        |=> !flags_r.c;
  endproperty
  a_logic_carry: assert property (p_logic_carry)
    else $error("carry not cleared");

  property p_result_hold;
    @(posedge clk_sys) disable iff (!rstn)
      (state_r != ST_T1) |=> $stable(result);
  endproperty
  a_result_hold: assert property (p_result_hold)
    else $error("result moved");

  property p_push;
    @(posedge clk_sys) disable iff (!rstn)
      pushFlags |-> flagsPushData == condition_flags_register;
  endproperty
  a_push: assert property (p_push) else $error("push data");

endmodule : acf_alu

// ===== acf_alu_tb_top.sv
`timescale 1ns/1ps
module acf_alu_tb_top
  import acf_pkg::*;
;
  logic        clk_sys, rstn, start, memDest, flagsWe, pushFlags;
  logic        retRestore, busy, regWe, memWe, reject;
  acf_op_e     op;
  logic [7:0]  srcA, srcB, result, expRes;
  logic [2:0]  shAmt;
  logic [3:0]  flagsWData, flagsPopData, flagsPushData;
  logic [3:0]  condition_flags_register;
  logic [4:0]  unsRel, sgnRel;
  acf_flags_s  expF;
  int          error_cnt, num_checks;
  logic [7:0]  opa [5] = '{8'hEA, 8'hBA, 8'hDC, 8'h80, 8'h00};
  logic [7:0]  opb [5] = '{8'h8C, 8'hC4, 8'h63, 8'h01, 8'h00};

  acf_alu acf_alu_inst (
    .clk_sys, .rstn, .start, .op, .srcA, .srcB, .shAmt, .memDest,
    .flagsWe, .flagsWData, .condition_flags_register, .pushFlags,
    .flagsPushData, .retRestore, .flagsPopData, .busy, .regWe, .memWe,
    .result, .reject, .unsRel, .sgnRel
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("Checks %0d, errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic set_flags(input logic [3:0] f);
    flagsWe = 1'b1;
    flagsWData = f;
    tick;
    flagsWe = 1'b0;
    expF = f;
    check(8'(condition_flags_register), 8'(f));
    check(8'(flagsPushData), 8'(f));
  endtask : set_flags

  // Reference outcome; mask marks the flags whose value is defined
  function automatic acf_result_s model(acf_op_e o, logic [7:0] a,
      logic [7:0] b, logic [2:0] n, acf_flags_s f);
    acf_result_s e;
    logic [8:0]  s;
    logic [15:0] d;
    logic        ci;
    e.flg = f;
    e.mask = 4'hF;
    e.wrRes = (o != ACF_OP_CMP) && (o != ACF_OP_BIT);
    ci = f.c & (o == ACF_OP_ADC || o == ACF_OP_SBC);
    d = 16'h0000;
    case (o)
      ACF_OP_ADD, ACF_OP_ADC: begin
        s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        e.flg.v = (a[7] == b[7]) && (s[7] != a[7]);
      end
      ACF_OP_SUB, ACF_OP_SBC, ACF_OP_CMP: begin
        s = {1'b0, a} - {1'b0, b} - {8'h00, ci};
        e.flg.v = (a[7] != b[7]) && (s[7] != a[7]);
      end
      ACF_OP_CPL: s = {1'b0, ~a};
      ACF_OP_OR:  s = {1'b0, a | b};
      ACF_OP_XOR: s = {1'b0, a ^ b};
      ACF_OP_SHL: s = {1'b0, a} << n;
      ACF_OP_SHR: begin
        d = {a, 8'h00} >> n;
        s = {d[7], d[15:8]};
      end
      ACF_OP_ROR: begin
        d = {a, a} >> n;
        s = {d[7], d[7:0]};
      end
      ACF_OP_NOP: s = {1'b0, a};
      default: s = {1'b0, a & b};
    endcase
    e.res = s[7:0];
    e.flg.c = s[8];
    e.flg.n = s[7];
    e.flg.z = (s[7:0] == 8'h00);
    // Overflow after a shift is left open, as is carry for a zero count
    if (o >= ACF_OP_SHL) e.mask = (n == 3'h0) ? 4'h9 : 4'hD;
    // An idle operation leaves every flag and the destination untouched
    if (o == ACF_OP_NOP) begin
      e.flg = f;
      e.mask = 4'hF;
      e.wrRes = 1'b0;
    end
    return e;
  endfunction : model

  task automatic run_op(input acf_op_e o, input logic [7:0] a,
      input logic [7:0] b, input logic [2:0] n, input logic m);
    acf_result_s      e;
    int               k;
    int               regAt;
    int               memAt;
    logic signed [7:0] sa;
    logic signed [7:0] sb;
    e = model(o, a, b, n, expF);
    sa = a;
    sb = b;
    regAt = 0;
    memAt = 0;
    k = 1;
    start = 1'b1;
    op = o;
    srcA = a;
    srcB = b;
    shAmt = n;
    memDest = m;
    tick;
    start = 1'b0;
    while (busy === 1'b1 && k < 8) begin
      if (regWe === 1'b1) regAt = k;
      if (memWe === 1'b1) memAt = k;
      tick;
      k++;
    end
    if (k >= 8) begin
      error_cnt++;
      report_and_stop;
    end
    check(8'(regAt), (e.wrRes && !m) ? 8'h02 : 8'h00);
    check(8'(memAt), (e.wrRes && m) ? 8'h03 : 8'h00);
    expRes = e.res;
    check(result, expRes);
    check(8'(condition_flags_register & e.mask), 8'(e.flg & e.mask));
    expF = e.flg;
    if (o == ACF_OP_SUB || o == ACF_OP_CMP) begin
      check(8'(unsRel), 8'({a > b, a >= b, a == b, a <= b, a < b}));
      check(8'(sgnRel), 8'({sa > sb, sa >= sb, a == b, sa <= sb,
                            sa < sb}));
    end
  endtask : run_op

  initial begin
    rstn = 1'b0;
    start = 1'b0;
    op = ACF_OP_NOP;
    {srcA, srcB, shAmt, memDest} = 20'h00000;
    {flagsWe, flagsWData, pushFlags, retRestore, flagsPopData} = 11'h000;
    error_cnt = 0;
    num_checks = 0;
    expF = 4'h0;
    expRes = 8'h00;
    repeat (5) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    check({busy, regWe, memWe, reject, condition_flags_register}, 8'h00);
    check(result, 8'h00);
    for (int i = 0; i < 10; i++) begin
      for (int j = 0; j < 5; j++) begin
        set_flags(4'(j * 3));
        run_op(acf_op_e'(i), opa[j], opb[j], 3'h0, j[0]);
      end
    end
    for (int i = 10; i < 13; i++) begin
      for (int k = 0; k < 8; k++) begin
        set_flags(4'h2);
        run_op(acf_op_e'(i), 8'hB5, 8'h00, 3'(k), 1'b0);
      end
      start = 1'b1;
      op = acf_op_e'(i);
      memDest = 1'b1;
      #1;
      check(8'(reject), 8'h01);
      tick;
      start = 1'b0;
      memDest = 1'b0;
      check(8'(busy), 8'h00);
    end
    // Sixteen-bit add then subtract, low byte first
    set_flags(4'h0);
    run_op(ACF_OP_ADD, 8'hF0, 8'h20, 3'h0, 1'b0);
    run_op(ACF_OP_ADC, 8'h12, 8'h0F, 3'h0, 1'b0);
    check(result, 8'h22);
    run_op(ACF_OP_SUB, 8'h00, 8'h01, 3'h0, 1'b0);
    run_op(ACF_OP_SBC, 8'h12, 8'h00, 3'h0, 1'b1);
    check(result, 8'h11);
    set_flags(4'h9);
    run_op(ACF_OP_NOP, 8'h5A, 8'h00, 3'h0, 1'b0);
    flagsWe = 1'b1;
    flagsWData = 4'h5;
    retRestore = 1'b1;
    flagsPopData = 4'hA;
    pushFlags = 1'b1;
    tick;
    {flagsWe, retRestore, pushFlags} = 3'h0;
    check(8'(condition_flags_register), 8'h0A);
    check(8'(flagsPushData), 8'h0A);
    flagsPopData = 4'h3;
    tick;
    check(8'(condition_flags_register), 8'h0A);
    // Reset in the middle of an operation
    start = 1'b1;
    op = ACF_OP_ADD;
    {srcA, srcB} = 16'hFF01;
    tick;
    start = 1'b0;
    rstn = 1'b0;
    #1;
    check({busy, regWe, memWe, 1'b0, condition_flags_register}, 8'h00);
    tick;
    rstn = 1'b1;
    tick;
    check(result, 8'h00);
    report_and_stop;
  end
endmodule : acf_alu_tb_top
